//--- logic/scr_pkg.sv
// shared constants and carriers of the synthesizer control block
// assumes one system clock of 20 MHz and a serial port clocked by the host
package scr_pkg;

   // serial frame layout: 24 data bits, 5 address bits, 3 chip bits
   localparam int REG_W    = 24;
   localparam int FRAME_W  = 32;
   localparam int CHIP_W   = 3;
   localparam int RADDR_W  = 5;
   localparam int CNT_W    = 6;
   localparam int RADDR_LO = CHIP_W;
   localparam int DATA_LO  = CHIP_W + RADDR_W;

   // register offsets
   localparam logic [4:0] OFS_ID     = 5'h00;
   localparam logic [4:0] OFS_PWR    = 5'h01;
   localparam logic [4:0] OFS_INT    = 5'h03;
   localparam logic [4:0] OFS_FRAC   = 5'h04;
   localparam logic [4:0] OFS_OSC    = 5'h05;
   localparam logic [4:0] OFS_SDM    = 5'h06;
   localparam logic [4:0] OFS_EXACT  = 5'h0C;
   localparam logic [4:0] OFS_OUTMUX = 5'h0F;

   // field positions
   localparam int BIT_SOFT_RST   = 5;
   localparam int BIT_PIN_CTL    = 0;
   localparam int BIT_REG_EN     = 1;
   localparam int KEEP_LO        = 2;
   localparam int KEEP_W         = 6;
   localparam int SEED_W         = 2;
   localparam int OUTSEL_W       = 5;
   localparam int BIT_NO_AUTOMUX = 6;
   localparam int BIT_FORCE_DRV  = 7;
   localparam int OSC_ADDR_LO    = 3;
   localparam int OSC_ADDR_W     = 4;
   localparam int OSC_DATA_LO    = 7;
   localparam int OSC_DATA_W     = 9;
   localparam int OSC_DEPTH      = 16;
   localparam int SIG_W          = 32;

   // reset values
   localparam logic [23:0] PWR_RST    = 24'h000003;
   localparam logic [23:0] INT_RST    = 24'h000000;
   localparam logic [23:0] FRAC_RST   = 24'h000000;
   localparam logic [23:0] SDM_RST    = 24'h000000;
   localparam logic [23:0] EXACT_RST  = 24'h000000;
   localparam logic [23:0] OUTMUX_RST = 24'h000001;
   localparam logic [23:0] CHIP_ID    = 24'h00A5C3; // arbitrary value

   // power-on delay
   localparam int POR_TIME_US = 250;
   localparam int CLK_MHZ     = 20;
   localparam int POR_CYCLES  = POR_TIME_US * CLK_MHZ;
   localparam int POR_W       = 16;

   typedef logic [OSC_DEPTH-1:0][OSC_DATA_W-1:0] scr_osc_t;

   // synthesizer settings handed to the modulator
   typedef struct packed {
      logic [REG_W-1:0]  int_div;
      logic [REG_W-1:0]  frac;
      logic [REG_W-1:0]  exact;
      logic [SEED_W-1:0] seed;
   } scr_cfg_s;

   // power enables of the analog side
   typedef struct packed {
      logic              analog_en;
      logic              clocks_en;
      logic [KEEP_W-1:0] keep_on;
   } scr_pwr_s;

endpackage

//--- logic/scr_top.sv
// control logic of the fractional synthesizer: registers, resets,
// power-down and the shared lock/readback output driver
// assumes SCK_I stops while the strobe is high and the strobe stays high
// for at least four system clocks so the system side can capture the frame
// and that RESETN_I is low while the supplies come up; it stands in for
// the supply detector and restarts the power-on delay each time it drops
// the oscillator bank is cleared only by that reset, never by a frame
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE_01: host changes exact channels by rewriting only the fractional register.
// RULE_02: host sets exact-step register to detector rate over common divisor.
// RULE_03: host sets fractional value as ceiling of scaled offset above boundary.
// RULE_04: host sets integer divide to floor of lowest channel over detector rate.
// RULE_05: exact stepping only when two adjacent channels meet the divisor floor.
// RULE_06: two-bit seed reloads into the phase accumulator on each fractional write.
// RULE_07: host should pick seed value two to avoid spurious correlation.
// RULE_08: every register returns to default about 250 us after power-up.
// RULE_09: soft reset bit clears synthesizer registers, leaving serial port mode.
// RULE_10: oscillator registers survive soft reset and chip enable pin.
// RULE_11: slow supplies call for a soft reset write before other traffic.
// RULE_12: host powers oscillator down indirectly before pulling chip enable low.
// RULE_13: under pin control a low chip enable stops analog and clocks.
// RULE_14: with pin control off, register bit one controls power-down.
// RULE_15: bits two to seven keep chosen blocks powered during power-down.
// RULE_16: after power-on the output driver is off except addressed reads.
// RULE_17: driver enables on chip address zero or strobe before address ends.
// RULE_18: force bit keeps the output driver always enabled.
// RULE_19: during a read the pin switches to readback data.
// RULE_20: no-automux bit keeps the general output signal on the pin.
// RULE_21: five-bit select chooses the general output signal, lock by default.
// RULE_22: a counter holds register reset until the power-on delay passes.
// RULE_23: driver enable and source change only at the strobe rising edge.
module scr_top #(
   parameter int POR_CYCLES = scr_pkg::POR_CYCLES
) (
   // system clock and reset
   input  wire  logic                       CLK_SYS_I,
   input  wire  logic                       RESETN_I,
   // serial port, clocked by the host
   input  wire  logic                       SCK_I,
   input  wire  logic                       SDI_I,
   input  wire  logic                       SERIAL_LATCH_STROBE_I,
   // power control pin
   input  wire  logic                       CHIP_ENABLE_PIN_I,
   // internal signals offered to the shared pin, index 1 is lock detect
   input  wire  logic [scr_pkg::SIG_W-1:0]  GENERAL_SIGNALS_I,
   // shared lock/readback pin
   output logic                             LOCK_READBACK_OUT_O,
   output logic                             LOCK_READBACK_OUT_OE_O,
   // settings for the modulator
   output scr_pkg::scr_cfg_s                SYNTH_CFG_O,
   output logic                             PHASE_ACCUMULATOR_LOAD_O,
   // power enables and oscillator settings
   output scr_pkg::scr_pwr_s                POWER_O,
   output scr_pkg::scr_osc_t                OSC_REGS_O
);
   import scr_pkg::*;

   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

   // all system-side state lives in one struct: the pin synchronisers,
   // the power-on counter, the register file and the pin driver state;
   // keeping it together lets the reset and soft reset work on one copy
   // state of the system clock domain
   typedef struct packed {
      logic                strb_m;
      logic                strb_s;
      logic                strb_d;
      logic                chen_m;
      logic                chen_s;
      logic [SIG_W-1:0]    sig_m;
      logic [SIG_W-1:0]    sig_s;
      logic [POR_W-1:0]    por_cnt;
      logic                por_busy;
      logic [RADDR_W-1:0]  rd_addr;
      logic [REG_W-1:0]    power_down_control;
      logic [REG_W-1:0]    int_div;
      logic [REG_W-1:0]    frac;
      logic [REG_W-1:0]    sdm;
      logic [REG_W-1:0]    exact;
      logic [REG_W-1:0]    outmux;
      scr_osc_t            osc;
      logic                seed_ld;
      logic                drive_en;
      logic                rb_sel;
      logic                sig_bit;
      logic [REG_W-1:0]    rb_word;
      scr_pwr_s            pwr;
   } scr_sys_s;

   // the serial side has no reset of its own: a frame is only trusted
   // once the strobe has marked its start, so stale bits are harmless
   // state of the serial clock domain
   typedef struct packed {
      logic [FRAME_W-1:0]  shreg;
      logic [CNT_W-1:0]    cnt;
      logic [REG_W-1:0]    rb_sh;
   } scr_link_s;

   scr_sys_s              sys_r;
   scr_sys_s              sys_nxt;
   scr_link_s             link_r;
   scr_link_s             link_nxt;
   logic                  fresh_r;
   logic                  strobe_rise;
   logic                  addressed;
   logic                  complete;
   logic [RADDR_W-1:0]    wr_addr;
   logic [REG_W-1:0]      wr_data;
   logic [OSC_ADDR_W-1:0] osc_addr;
   logic                  power_on;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   // the functions below serve the frame decode, the resets and the
   // readback path; the write decode and reg_read each list their own offsets

   // a zero address is ours; a frame cut short before its address is
   // complete counts as ours too, so the driver turns on
   // chip address check; bits not yet clocked in cannot disqualify the frame
   function automatic logic chip_match(input logic [FRAME_W-1:0] sh,
                                       input logic [CNT_W-1:0]   cnt);
      int  seen;
      logic ok;
      seen = int'(cnt) - (FRAME_W - CHIP_W);
      ok   = 1'b1;
      for (int i = 0; i < CHIP_W; i++) begin
         if (i < seen) begin
            ok = ok & ~sh[i];
         end
      end
      return ok;
   endfunction

   // used by the power-on delay, the soft reset bit and RESETN_I alike
   // synthesizer registers to defaults; oscillator bank left alone
   function automatic scr_sys_s synth_defaults(input scr_sys_s s);
      scr_sys_s d;
      d                    = s;
      d.rd_addr            = '0;
      d.power_down_control = PWR_RST;
      d.int_div            = INT_RST;
      d.frac               = FRAC_RST;
      d.sdm                = SDM_RST;
      d.exact              = EXACT_RST;
      d.outmux             = OUTMUX_RST;
      return d;
   endfunction

   // the identity word is a constant; the oscillator bank is write only
   // readback word for the register named by the read address
   function automatic logic [REG_W-1:0] reg_read(input scr_sys_s s);
      logic [REG_W-1:0] v;
      v = '0;
      case (s.rd_addr)
         OFS_ID:     v = CHIP_ID;
         OFS_PWR:    v = s.power_down_control;
         OFS_INT:    v = s.int_div;
         OFS_FRAC:   v = s.frac;
         OFS_SDM:    v = s.sdm;
         OFS_EXACT:  v = s.exact;
         OFS_OUTMUX: v = s.outmux;
         default:    v = '0;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // serial clock domain
   // this side runs only while the host clocks a frame; SCK_I is
   // dead between frames, so nothing here may wait for a later edge
   // to finish its work. the strobe doubles as an asynchronous set of
   // the frame start flag because no clock edge follows it in time

   // frame start marker; set by the strobe, so the next clock edge restarts the bit count
   always_ff @(posedge SCK_I or posedge SERIAL_LATCH_STROBE_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fresh_r <= 1'b1;
      end else if (SERIAL_LATCH_STROBE_I) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // shift in the frame and shift out the readback word, MSB first
   always_comb begin
      link_nxt       = link_r;
      link_nxt.shreg = {link_r.shreg[FRAME_W-2:0], SDI_I};
      if (fresh_r) begin
         link_nxt.cnt   = CNT_W'(1);
         // rb_word is static here: it changed while the strobe was high
         link_nxt.rb_sh = sys_r.rb_word;                    // RULE_19
      end else begin
         // saturate so long frames still count as complete
         if (link_r.cnt != '1) begin
            link_nxt.cnt = link_r.cnt + CNT_W'(1);
         end
         link_nxt.rb_sh = {link_r.rb_sh[REG_W-2:0], 1'b0};
      end
   end

   // shift register and counter; no reset needed, see above
   always_ff @(posedge SCK_I) begin
      link_r <= link_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // frame decode, read by the system domain only after the strobe rises,
   // when the serial clock has stopped and the frame is quasi-static
   // the decode is combinational on the serial flops; it settles long
   // before the synchronised strobe edge reaches the system side, which
   // is why the strobe must stay high for a few system clocks

   assign strobe_rise = sys_r.strb_s & ~sys_r.strb_d;
   assign complete    = (int'(link_r.cnt) >= FRAME_W);
   assign addressed   = chip_match(link_r.shreg, link_r.cnt);      // RULE_17
   assign wr_addr     = link_r.shreg[RADDR_LO +: RADDR_W];
   assign wr_data     = link_r.shreg[DATA_LO +: REG_W];
   assign osc_addr    = wr_data[OSC_ADDR_LO +: OSC_ADDR_W];

   // power-down source: pin or register bit
   assign power_on = sys_r.power_down_control[BIT_PIN_CTL] ?
                     sys_r.chen_s :                              // RULE_13
                     sys_r.power_down_control[BIT_REG_EN];       // RULE_14

   ////////////////////////////////////////////////////////////////////////
   // system clock domain
   // one combinational pass works out the next state; the order of the
   // blocks below sets priority: reset over power-on delay over frames

   always_comb begin
      sys_nxt = sys_r;

      // pins pass two flip-flops before use
      sys_nxt.strb_m = SERIAL_LATCH_STROBE_I;
      sys_nxt.strb_s = sys_r.strb_m;
      sys_nxt.strb_d = sys_r.strb_s;
      sys_nxt.chen_m = CHIP_ENABLE_PIN_I;
      sys_nxt.chen_s = sys_r.chen_m;
      sys_nxt.sig_m  = GENERAL_SIGNALS_I;
      sys_nxt.sig_s  = sys_r.sig_m;

      sys_nxt.seed_ld = 1'b0;

      if (sys_r.por_busy) begin
         // frames that arrive now are dropped without a trace
         // hold everything at default until the delay has run out
         sys_nxt          = synth_defaults(sys_nxt);         // RULE_08
         sys_nxt.osc      = '0;
         sys_nxt.drive_en = 1'b0;                            // RULE_16
         sys_nxt.rb_sel   = 1'b0;
         if (sys_r.por_cnt == POR_LAST) begin
            sys_nxt.por_busy = 1'b0;                         // RULE_22
         end else begin
            sys_nxt.por_cnt = sys_r.por_cnt + POR_W'(1);     // RULE_22
         end
      end else if (strobe_rise) begin
         if (addressed && complete) begin
            case (wr_addr)
               OFS_ID: begin
                  if (wr_data[BIT_SOFT_RST]) begin
                     // oscillator bank is kept on purpose
                     sys_nxt = synth_defaults(sys_nxt);      // RULE_09 RULE_10
                  end else begin
                     sys_nxt.rd_addr = wr_data[RADDR_W-1:0];
                  end
               end
               OFS_PWR:    sys_nxt.power_down_control = wr_data;
               OFS_INT:    sys_nxt.int_div = wr_data;
               OFS_FRAC: begin
                  sys_nxt.frac    = wr_data;
                  sys_nxt.seed_ld = 1'b1;                    // RULE_06
               end
               OFS_OSC: begin
                  sys_nxt.osc[osc_addr] = wr_data[OSC_DATA_LO +: OSC_DATA_W];
               end
               OFS_SDM:    sys_nxt.sdm = wr_data;
               OFS_EXACT:  sys_nxt.exact = wr_data;
               OFS_OUTMUX: sys_nxt.outmux = wr_data;
               default:    sys_nxt.rd_addr = sys_nxt.rd_addr;
            endcase
         end
         // an unaddressed frame still updates the driver state
         // driver and source only move here, never mid-frame
         sys_nxt.drive_en = sys_nxt.outmux[BIT_FORCE_DRV] |
                            addressed;                       // RULE_17 RULE_18 RULE_23
         sys_nxt.rb_sel   = addressed &
                            ~sys_nxt.outmux[BIT_NO_AUTOMUX]; // RULE_19 RULE_20 RULE_23
         sys_nxt.rb_word  = reg_read(sys_nxt);
      end

      // the select field moves only on a frame, the signals themselves
      // arrive through the two-stage synchroniser above
      // selected general signal, registered so the pin sees a flop
      sys_nxt.sig_bit = sys_r.sig_s[sys_r.outmux[OUTSEL_W-1:0]]; // RULE_21

      // a kept block stays up whatever the power-down source says
      // power enables; keep bits hold single blocks up in power-down
      sys_nxt.pwr.analog_en = power_on;                      // RULE_13
      sys_nxt.pwr.clocks_en = power_on;                      // RULE_13
      sys_nxt.pwr.keep_on   = sys_r.power_down_control[KEEP_LO +: KEEP_W] |
                              {KEEP_W{power_on}};            // RULE_15

      // placed last so that it overrides every branch above
      // reset restarts the power-on delay; supply loss clears the oscillator
      if (!RESETN_I) begin
         sys_nxt          = '0;
         sys_nxt          = synth_defaults(sys_nxt);         // RULE_08 RULE_10
         sys_nxt.por_busy = 1'b1;                            // RULE_22
      end
   end

   // the only system-side register stage
   always_ff @(posedge CLK_SYS_I) begin
      sys_r <= sys_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // the pin mux reads one flop of each domain; a change of source
   // happens only at a strobe, when the serial flop is idle

   // source select is stable between strobes, so the mux cannot glitch
   // inside a frame; outside frames the readback flop simply holds
   assign LOCK_READBACK_OUT_O    = sys_r.rb_sel ? link_r.rb_sh[REG_W-1] :
                                                  sys_r.sig_bit;   // RULE_19
   assign LOCK_READBACK_OUT_OE_O = sys_r.drive_en;                 // RULE_16

   // modulator settings straight from the register flops
   assign SYNTH_CFG_O.int_div    = sys_r.int_div;
   assign SYNTH_CFG_O.frac       = sys_r.frac;
   assign SYNTH_CFG_O.exact      = sys_r.exact;
   assign SYNTH_CFG_O.seed       = sys_r.sdm[SEED_W-1:0];
   assign PHASE_ACCUMULATOR_LOAD_O = sys_r.seed_ld;

   // power and oscillator outputs
   assign POWER_O    = sys_r.pwr;
   assign OSC_REGS_O = sys_r.osc;

endmodule

//--- sim/scr_top_props.sv
// checker of the synthesizer control block, seen from its ports only
// assumes it is bound to scr_top from the bench top file
`timescale 1ns/100ps
module scr_top_props #(
   parameter int POR_CYCLES = 20
) (
   // clock, reset and inputs
   input wire logic                      CLK_SYS_I,
   input wire logic                      RESETN_I,
   input wire logic                      SCK_I,
   input wire logic                      SDI_I,
   input wire logic                      SERIAL_LATCH_STROBE_I,
   input wire logic                      CHIP_ENABLE_PIN_I,
   input wire logic [scr_pkg::SIG_W-1:0] GENERAL_SIGNALS_I,
   // outputs
   input wire logic                      LOCK_READBACK_OUT_O,
   input wire logic                      LOCK_READBACK_OUT_OE_O,
   input wire scr_pkg::scr_cfg_s         SYNTH_CFG_O,
   input wire logic                      PHASE_ACCUMULATOR_LOAD_O,
   input wire scr_pkg::scr_pwr_s         POWER_O,
   input wire scr_pkg::scr_osc_t         OSC_REGS_O
);
   import scr_pkg::*;
   int unsigned por_cnt_r;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   ////////////////////////////////////////
   // cycles since reset release, saturating so it never wraps
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) por_cnt_r <= 0;
      else if (por_cnt_r <= POR_CYCLES) por_cnt_r <= por_cnt_r + 1;
   end
   sequence frame_held_s;
      SERIAL_LATCH_STROBE_I [*2];
   endsequence
   por_quiet_a: assert property (por_cnt_r < POR_CYCLES |->
      !PHASE_ACCUMULATOR_LOAD_O && !LOCK_READBACK_OUT_OE_O) else $error("activity in por delay");
   load_origin_a: assert property (PHASE_ACCUMULATOR_LOAD_O |->
      $past(SERIAL_LATCH_STROBE_I, 2) && !$past(PHASE_ACCUMULATOR_LOAD_O)) else $error("bad load");
   cfg_frame_a: assert property ($changed(SYNTH_CFG_O) |->
      $past(SERIAL_LATCH_STROBE_I)) else $error("cfg changed outside frame");
   oe_strobe_a: assert property ($changed(LOCK_READBACK_OUT_OE_O) |->
      $past(SERIAL_LATCH_STROBE_I)) else $error("oe changed outside strobe");
   osc_frame_a: assert property ($changed(OSC_REGS_O) |->
      $past(SERIAL_LATCH_STROBE_I)) else $error("osc bank changed outside frame");
   power_keep_a: assert property (POWER_O.analog_en |-> &POWER_O.keep_on)
      else $error("keep_on low while powered");
   power_clk_a: assert property (POWER_O.clocks_en == POWER_O.analog_en)
      else $error("clocks differ from analog");
   clk_off_a: assert property (!POWER_O.analog_en |-> !POWER_O.clocks_en)
      else $error("clocks on while powered down");
   power_cause_a: assert property (por_cnt_r > 4 && $changed(POWER_O.analog_en) |->
      $past(CHIP_ENABLE_PIN_I, 2) != $past(CHIP_ENABLE_PIN_I, 4) ||
      $past(SERIAL_LATCH_STROBE_I, 2)) else $error("power change without cause");
   load_cov_c: cover property (frame_held_s ##[1:3] PHASE_ACCUMULATOR_LOAD_O);
   load_pulse_a: assert property (PHASE_ACCUMULATOR_LOAD_O |=>
      !PHASE_ACCUMULATOR_LOAD_O) else $error("load pulse longer than one cycle");
   // while powered down, keep bits may only move after a register write
   keep_frame_a: assert property (!POWER_O.analog_en && $stable(POWER_O.analog_en) &&
      $changed(POWER_O.keep_on) |-> $past(SERIAL_LATCH_STROBE_I, 2))
      else $error("keep bits moved outside frame");
endmodule

//--- sim/scr_host_model.sv
// host on the far side of the serial port: sends frames, collects readback
// assumes the device shifts readback on rising edges; sampled at falling
`timescale 1ns/100ps
module scr_host_model (
   // serial lines to the device
   output logic      sck_o,
   output logic      sdi_o,
   output logic      stb_o,
   // shared pin from the device
   input  wire logic rb_i
);
   logic [23:0] rb_r;
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      stb_o = 1'b0;
   end
   ////////////////////////////////////////
   // clock runs only inside frames; sdi inverts when released so no stale bit
   task automatic frame(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o <= w[i];
         #32 sck_o <= 1'b1;
         #32 sck_o <= 1'b0;
         if (n - i <= 24) rb_r[24 - (n - i)] = rb_i;
      end
      sdi_o <= ~sdi_o;
      #32 stb_o <= 1'b1; // held 8 system clocks, twice the minimum
      #400 stb_o <= 1'b0;
      #400;
   endtask
endmodule

//--- sim/scr_top_tb.sv
// self-checking bench of the synthesizer control block
// assumes the host model owns the serial lines and times them itself
`timescale 1ns/100ps
module scr_top_tb;
   import scr_pkg::*;
   localparam int PORC = 200;
   logic             clk, rstn, sck, sdi, stb, ce, pin, oe, ld, bus;
   logic [SIG_W-1:0] gen;
   logic [23:0]      fr, rb;
   logic [7:0]       r1;
   logic [4:0]       sel;
   scr_cfg_s         cfg;
   scr_pwr_s         pwr;
   scr_osc_t         osc;
   int               n_mismatch, num_checks, n_load, nl, cyc;
   scr_top #(.POR_CYCLES(PORC)) i_scr_top (.CLK_SYS_I(clk), .RESETN_I(rstn), .SCK_I(sck),
      .SDI_I(sdi), .SERIAL_LATCH_STROBE_I(stb), .CHIP_ENABLE_PIN_I(ce),
      .GENERAL_SIGNALS_I(gen), .LOCK_READBACK_OUT_O(pin), .LOCK_READBACK_OUT_OE_O(oe),
      .SYNTH_CFG_O(cfg), .PHASE_ACCUMULATOR_LOAD_O(ld), .POWER_O(pwr), .OSC_REGS_O(osc));
   // a released line shows the inverse, so a read without the driver fails
   assign bus = oe ? pin : ~pin;
   scr_host_model i_scr_host_model (.sck_o(sck), .sdi_o(sdi), .stb_o(stb), .rb_i(bus));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////
   // load pulses and hang guard
   always @(posedge clk) begin
      if (ld === 1'b1) n_load++;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // frame starts off the clock edge, so link and system phases drift apart
   task automatic wr(input logic [4:0] a, input logic [23:0] d, input logic [2:0] c = 3'h0,
                     input int n = 32);
      @(posedge clk);
      #7 i_scr_host_model.frame({d, a, c}, n);
   endtask
   task automatic rd(input logic [4:0] a, output logic [23:0] v);
      wr(OFS_ID, {19'h0, a});
      wr(OFS_ID, {19'h0, a});
      v = i_scr_host_model.rb_r;
   endtask
   function automatic scr_pwr_s exp_pwr(input logic [7:0] r, input logic p);
      logic on;
      on = r[0] ? p : r[1];
      return '{on, on, r[7:2] | {6{on}}};
   endfunction
   localparam scr_cfg_s CFG_DEF = '{INT_RST, FRAC_RST, EXACT_RST, SDM_RST[1:0]};
   ////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      gen = 32'h0000_0002;
      void'($urandom(32'h2471));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      wr(OFS_FRAC, 24'h123456);
      check(cfg, CFG_DEF);
      repeat (PORC) @(posedge clk);
      check(n_load, 0);
      check(oe, 1'b0);
      wr(OFS_ID, 24'h000020);
      check(cfg, CFG_DEF);
      check(pwr, exp_pwr(PWR_RST[7:0], 1'b1));
      rd(OFS_PWR, rb);
      check(rb, PWR_RST);
      rd(5'h1F, rb);
      check(rb, 24'h0);
      $display("test reset done");
      wr(OFS_INT, 24'h00002D);
      wr(OFS_EXACT, 24'h000C00);
      wr(OFS_SDM, 24'h000002);
      for (int k = 0; k < 6; k++) begin
         fr = (k == 0) ? 24'h938000 : (k == 1) ? 24'h93EAAB : 24'($urandom());
         nl = n_load;
         wr(OFS_FRAC, fr);
         check(n_load - nl, 1);
         check(cfg, {24'h2D, fr, 24'hC00, 2'h2});
      end
      rd(OFS_FRAC, rb);
      check(rb, fr);
      check(oe, 1'b1);
      wr(OFS_FRAC, ~fr, 3'h5);
      check(cfg.frac, fr);
      check(oe, 1'b0);
      wr(OFS_FRAC, 24'h0, 3'h0, 20);
      check(oe, 1'b1);
      check(cfg.frac, fr);
      $display("test channel done");
      for (int k = 0; k < 3; k++) begin
         sel = (k == 0) ? 5'h01 : 5'($urandom());
         @(posedge clk) gen <= $urandom();
         wr(OFS_OUTMUX, {16'h0, 3'b010, sel});
         rd(OFS_FRAC, rb);
         check(rb, {24{gen[sel]}});
      end
      wr(OFS_OUTMUX, 24'h000081);
      wr(OFS_INT, 24'h00002D, 3'h3);
      check(oe, 1'b1);
      wr(OFS_OUTMUX, 24'h000001);
      wr(OFS_INT, 24'h00002D, 3'h3);
      check(oe, 1'b0);
      $display("test pin done");
      for (int k = 0; k < 8; k++) begin
         r1 = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : 8'($urandom());
         @(posedge clk) ce <= (k < 2) ? 1'b0 : 1'($urandom());
         wr(OFS_PWR, {16'h0, r1});
         check(pwr, exp_pwr(r1, ce));
      end
      $display("test power done");
      wr(OFS_OSC, {8'h0, 9'h1A5, 4'h3, 3'h0});
      wr(OFS_OSC, {8'h0, 9'h000, 4'h1, 3'h0});
      @(posedge clk) ce <= 1'b0;
      wr(OFS_ID, 24'h000020);
      check(cfg, CFG_DEF);
      check(pwr, exp_pwr(PWR_RST[7:0], 1'b0));
      check(osc[3], 9'h1A5);
      check(osc[1], 9'h000);
      $display("test osc done");
      give_verdict();
   end
endmodule
bind scr_top scr_top_props #(.POR_CYCLES(POR_CYCLES)) i_scr_top_props (
   .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .SCK_I(SCK_I), .SDI_I(SDI_I),
   .SERIAL_LATCH_STROBE_I(SERIAL_LATCH_STROBE_I), .CHIP_ENABLE_PIN_I(CHIP_ENABLE_PIN_I),
   .GENERAL_SIGNALS_I(GENERAL_SIGNALS_I), .LOCK_READBACK_OUT_O(LOCK_READBACK_OUT_O),
   .LOCK_READBACK_OUT_OE_O(LOCK_READBACK_OUT_OE_O), .SYNTH_CFG_O(SYNTH_CFG_O),
   .PHASE_ACCUMULATOR_LOAD_O(PHASE_ACCUMULATOR_LOAD_O), .POWER_O(POWER_O),
   .OSC_REGS_O(OSC_REGS_O));
